/* plti_consts.vh */
// constants for the proximity and light threshold interrupt block
`ifndef PLTI_CONSTS_VH
`define PLTI_CONSTS_VH

// bus address: base with the select pin in bit 0
`define PLTI_I2C_ADDR_BASE 7'h38

// register offsets
`define PLTI_REG_SYS_CMD 8'h40
`define PLTI_REG_PERSIST 8'h43
`define PLTI_REG_INT_CTRL 8'h4a
`define PLTI_REG_PLT_LO 8'h4d
`define PLTI_REG_PLT_HI 8'h4e
`define PLTI_REG_LHT_LO 8'h4f
`define PLTI_REG_LHT_HI 8'h50
`define PLTI_REG_LLT_LO 8'h51
`define PLTI_REG_LLT_HI 8'h52

// reset values
`define PLTI_RST_PLT_LO 8'h00
`define PLTI_RST_PLT_HI 4'h0
`define PLTI_RST_LHT 8'hff
`define PLTI_RST_LLT 8'h00
`define PLTI_RST_INT_CTRL 6'h00
`define PLTI_RST_PERSIST 4'h0

// command register bits
`define PLTI_CMD_SW_RST 7
`define PLTI_CMD_INT_RST 6

// interrupt control fields
`define PLTI_IC_PROX_STAT 7
`define PLTI_IC_LIGHT_STAT 6
`define PLTI_IC_MODE_HI 5
`define PLTI_IC_MODE_LO 4
`define PLTI_IC_ASSERT 3
`define PLTI_IC_UPDATE 2
`define PLTI_IC_TRIG_HI 1
`define PLTI_IC_TRIG_LO 0

// proximity compare modes
`define PLTI_PMODE_HIGH 2'b00
`define PLTI_PMODE_HYST 2'b01
`define PLTI_PMODE_OUTSIDE 2'b10

// release gap when re-asserting the pin
`define PLTI_REASSERT_NS 1000
`define PLTI_CLK_MHZ 20
// 1000 ns at 20 MHz, sized for the six-bit gap counter
`define PLTI_REASSERT_CYC 6'h14

`endif

/* plti_sync.v */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module plti_sync #(
  parameter W = 1
) (
  input wire i_clk, // block clock
  input wire i_rst, // sync reset, active high
  input wire [W-1:0] i_async, // pin level
  input wire [W-1:0] i_rst_val, // level held during reset
  output reg [W-1:0] o_sync // synchronised level
);
  reg [W-1:0] meta_r;

  // first stage feeds only the second
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= i_rst_val;
      o_sync <= i_rst_val;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // plti_sync

/* plti_top.v */
// threshold interrupt logic with its serial register slave
`timescale 1ns/100ps
`include "plti_consts.vh"

// How it works
// - 12-bit proximity low threshold in two bytes, both reset zero.
// - 16-bit light high threshold, low byte first, resets all ones.
// - 16-bit light low threshold, low byte first, resets zero.
// - comparison status readable in interrupt control and at the pin.
// - persistence filter applies to proximity only, set in its own register.
// - pin is open drain, pulls low when active, released after power-up.
// - reset command, status read or software reset clear the status.
// - standby does not change the interrupt status.
// - latched status stays active until reset command, status read or software reset.
// - light active outside low-to-high window, inactive inside; fixed.
// - mode 00: active when proximity at or above high threshold.
// - mode 01: set above high, clear below low, else hold.
// - mode 10: active outside threshold range, inactive inside.
// - bus address 0x38 with select pin low, 0x39 with it high.
// - assert bit: steady low, or release and re-assert per new result.
module plti_top (
  input wire i_clk, // 20 MHz block clock
  input wire i_rst, // sync reset, active high
  input wire i_scl, // bus clock pin level
  input wire i_sda, // bus data pin level
  output reg o_sda_o, // bus data drive value, always low
  output reg o_sda_oe, // bus data pull-low enable
  input wire i_addr_sel, // address select pin
  output reg o_int_o, // interrupt drive value, always low
  output reg o_int_oe, // interrupt pull-low enable
  input wire [11:0] i_prox_high_thr, // proximity high threshold
  input wire i_prox_valid, // proximity result strobe
  input wire [11:0] i_prox_data, // proximity result
  input wire i_light_valid, // light result strobe
  input wire [15:0] i_light_data // visible light result
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_AACK = 4'h2;
  localparam [3:0] S_REG = 4'h3;
  localparam [3:0] S_RACK = 4'h4;
  localparam [3:0] S_WR = 4'h5;
  localparam [3:0] S_WACK = 4'h6;
  localparam [3:0] S_RD = 4'h7;
  localparam [3:0] S_MACK = 4'h8;
  localparam [5:0] GAP_CYC = `PLTI_REASSERT_CYC;

  // pins cross into the block clock
  wire [2:0] pins_s;
  plti_sync #(
    .W(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_scl, i_sda, i_addr_sel}),
    .i_rst_val(3'h7),
    .o_sync(pins_s)
  );
  wire scl_s = pins_s[2];
  wire sda_s = pins_s[1];
  wire addr_s = pins_s[0];

  reg scl_d_r;
  reg sda_d_r;
  reg [3:0] state_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg [7:0] tx_r;
  reg [7:0] ptr_r;
  reg rw_r;
  reg nack_r;
  reg wr_en_r;
  reg [7:0] wr_addr_r;
  reg [7:0] wr_data_r;
  reg rd_clr_r;

  reg [7:0] plt_lo_r;
  reg [3:0] plt_hi_r;
  reg [7:0] lht_lo_r;
  reg [7:0] lht_hi_r;
  reg [7:0] llt_lo_r;
  reg [7:0] llt_hi_r;
  reg [5:0] ictl_r;
  reg [3:0] persist_r;
  reg prox_stat_r;
  reg light_stat_r;
  reg hyst_r;
  reg [3:0] pcnt_r;
  reg [5:0] gap_r;

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire [6:0] my_addr = `PLTI_I2C_ADDR_BASE | {6'h00, addr_s};

  // same decode serves both the read mux and the write port
  function is_reg;
    input [7:0] a;
    input [7:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (is_reg(ptr_r, `PLTI_REG_PERSIST))
      rd_byte = {4'h0, persist_r};
    else if (is_reg(ptr_r, `PLTI_REG_INT_CTRL))
      rd_byte = {prox_stat_r, light_stat_r, ictl_r};
    else if (is_reg(ptr_r, `PLTI_REG_PLT_LO))
      rd_byte = plt_lo_r;
    else if (is_reg(ptr_r, `PLTI_REG_PLT_HI))
      rd_byte = {4'h0, plt_hi_r};
    else if (is_reg(ptr_r, `PLTI_REG_LHT_LO))
      rd_byte = lht_lo_r;
    else if (is_reg(ptr_r, `PLTI_REG_LHT_HI))
      rd_byte = lht_hi_r;
    else if (is_reg(ptr_r, `PLTI_REG_LLT_LO))
      rd_byte = llt_lo_r;
    else if (is_reg(ptr_r, `PLTI_REG_LLT_HI))
      rd_byte = llt_hi_r;
  end

  // serial slave: sample at clock rise, drive data after clock fall
  always @(posedge i_clk) begin
    if (i_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      rd_clr_r <= 1'b0;
      o_sda_o <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wr_en_r <= 1'b0;
      rd_clr_r <= 1'b0;
      if (start_cond) begin
        state_r <= S_ADDR;
        cnt_r <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state_r <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state_r == S_ADDR || state_r == S_REG || state_r == S_WR) begin
          sh_r <= {sh_r[6:0], sda_s};
          cnt_r <= cnt_r + 4'h1;
        end else if (state_r == S_MACK) begin
          nack_r <= sda_s;
        end
      end else if (scl_fall) begin
        case (state_r)
          S_ADDR: begin
            if (cnt_r == 4'h8) begin
              if (sh_r[7:1] == my_addr) begin
                rw_r <= sh_r[0];
                o_sda_oe <= 1'b1;
                state_r <= S_AACK;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              tx_r <= rd_byte;
              o_sda_oe <= ~rd_byte[7];
              state_r <= S_RD;
            end else begin
              o_sda_oe <= 1'b0;
              state_r <= S_REG;
            end
          end
          S_REG: begin
            if (cnt_r == 4'h8) begin
              ptr_r <= sh_r;
              o_sda_oe <= 1'b1;
              state_r <= S_RACK;
            end
          end
          S_RACK: begin
            o_sda_oe <= 1'b0;
            cnt_r <= 4'h0;
            state_r <= S_WR;
          end
          S_WR: begin
            if (cnt_r == 4'h8) begin
              wr_en_r <= 1'b1;
              wr_addr_r <= ptr_r;
              wr_data_r <= sh_r;
              o_sda_oe <= 1'b1;
              state_r <= S_WACK;
            end
          end
          S_WACK: begin
            o_sda_oe <= 1'b0;
            cnt_r <= 4'h0;
            ptr_r <= ptr_r + 8'h01;
            state_r <= S_WR;
          end
          S_RD: begin
            if (cnt_r == 4'h7) begin
              o_sda_oe <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
              // the status byte has left: drop the status now
              rd_clr_r <= is_reg(ptr_r, `PLTI_REG_INT_CTRL);
              state_r <= S_MACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              o_sda_oe <= ~tx_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
          S_MACK: begin
            cnt_r <= 4'h0;
            if (nack_r) begin
              o_sda_oe <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              tx_r <= rd_byte;
              o_sda_oe <= ~rd_byte[7];
              state_r <= S_RD;
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  wire wr_cmd = wr_en_r & is_reg(wr_addr_r, `PLTI_REG_SYS_CMD);
  wire sw_rst = wr_cmd & wr_data_r[`PLTI_CMD_SW_RST];
  wire int_rst = wr_cmd & wr_data_r[`PLTI_CMD_INT_RST];

  // threshold and control registers
  always @(posedge i_clk) begin
    if (i_rst || sw_rst) begin
      plt_lo_r <= `PLTI_RST_PLT_LO;
      plt_hi_r <= `PLTI_RST_PLT_HI;
      lht_lo_r <= `PLTI_RST_LHT;
      lht_hi_r <= `PLTI_RST_LHT;
      llt_lo_r <= `PLTI_RST_LLT;
      llt_hi_r <= `PLTI_RST_LLT;
      ictl_r <= `PLTI_RST_INT_CTRL;
      persist_r <= `PLTI_RST_PERSIST;
    end else if (wr_en_r) begin
      if (is_reg(wr_addr_r, `PLTI_REG_PLT_LO))
        plt_lo_r <= wr_data_r;
      if (is_reg(wr_addr_r, `PLTI_REG_PLT_HI))
        plt_hi_r <= wr_data_r[3:0];
      if (is_reg(wr_addr_r, `PLTI_REG_LHT_LO))
        lht_lo_r <= wr_data_r;
      if (is_reg(wr_addr_r, `PLTI_REG_LHT_HI))
        lht_hi_r <= wr_data_r;
      if (is_reg(wr_addr_r, `PLTI_REG_LLT_LO))
        llt_lo_r <= wr_data_r;
      if (is_reg(wr_addr_r, `PLTI_REG_LLT_HI))
        llt_hi_r <= wr_data_r;
      // status bits are read only
      if (is_reg(wr_addr_r, `PLTI_REG_INT_CTRL))
        ictl_r <= wr_data_r[5:0];
      if (is_reg(wr_addr_r, `PLTI_REG_PERSIST))
        persist_r <= wr_data_r[3:0];
    end
  end

  wire [11:0] plt = {plt_hi_r, plt_lo_r};
  wire [15:0] lht = {lht_hi_r, lht_lo_r};
  wire [15:0] llt = {llt_hi_r, llt_lo_r};
  wire [1:0] pmode = ictl_r[`PLTI_IC_MODE_HI:`PLTI_IC_MODE_LO];
  wire assert_rep = ictl_r[`PLTI_IC_ASSERT];
  wire upd_mode = ictl_r[`PLTI_IC_UPDATE];
  wire trig_px = ictl_r[`PLTI_IC_TRIG_LO];
  wire trig_lt = ictl_r[`PLTI_IC_TRIG_HI];

  // raw proximity condition for the current result
  reg prox_raw;
  always @* begin
    prox_raw = 1'b0;
    case (pmode)
      `PLTI_PMODE_HIGH: prox_raw = (i_prox_data >= i_prox_high_thr);
      `PLTI_PMODE_HYST: begin
        if (i_prox_data > i_prox_high_thr)
          prox_raw = 1'b1;
        else if (i_prox_data < plt)
          prox_raw = 1'b0;
        else
          prox_raw = hyst_r;
      end
      `PLTI_PMODE_OUTSIDE:
        prox_raw = (i_prox_data > i_prox_high_thr) | (i_prox_data < plt);
      default: prox_raw = 1'b0;
    endcase
  end

  // a persistence of n wants n active results in a row
  wire [4:0] pcnt_inc = {1'b0, pcnt_r} + 5'h01;
  wire prox_act = prox_raw & (pcnt_inc >= {1'b0, persist_r});
  wire light_act = (i_light_data > lht) | (i_light_data < llt);
  wire clr_stat = int_rst | rd_clr_r | sw_rst;

  reg prox_stat_nxt;
  reg light_stat_nxt;
  always @* begin
    prox_stat_nxt = prox_stat_r;
    light_stat_nxt = light_stat_r;
    // no standby input touches status; only the clear causes and new results do
    if (clr_stat) begin
      prox_stat_nxt = 1'b0;
      light_stat_nxt = 1'b0;
    end
    // a result in the clearing cycle still wins, except when the clear is a software reset
    if (i_prox_valid && !sw_rst) begin
      if (upd_mode)
        prox_stat_nxt = prox_act;
      else if (prox_act)
        prox_stat_nxt = 1'b1;
    end
    if (i_light_valid && !sw_rst) begin
      if (upd_mode)
        light_stat_nxt = light_act;
      else if (light_act)
        light_stat_nxt = 1'b1;
    end
  end

  wire new_act = (i_prox_valid & prox_act & trig_px) |
                 (i_light_valid & light_act & trig_lt);
  wire pin_cond = (prox_stat_r & trig_px) | (light_stat_r & trig_lt);

  always @(posedge i_clk) begin
    if (i_rst) begin
      prox_stat_r <= 1'b0;
      light_stat_r <= 1'b0;
      hyst_r <= 1'b0;
      pcnt_r <= 4'h0;
      gap_r <= 6'h00;
      o_int_o <= 1'b0;
      o_int_oe <= 1'b0;
    end else begin
      prox_stat_r <= prox_stat_nxt;
      light_stat_r <= light_stat_nxt;
      if (sw_rst) begin
        hyst_r <= 1'b0;
        pcnt_r <= 4'h0;
      end else if (i_prox_valid) begin
        hyst_r <= prox_raw;
        if (!prox_raw)
          pcnt_r <= 4'h0;
        else if (pcnt_r != 4'hf)
          pcnt_r <= pcnt_inc[3:0];
      end
      // a repeat result while low gives the host a fresh falling edge
      if (assert_rep && new_act && o_int_oe)
        gap_r <= GAP_CYC;
      else if (gap_r != 6'h00)
        gap_r <= gap_r - 6'h01;
      o_int_oe <= pin_cond && (gap_r == 6'h00) &&
                  !(assert_rep && new_act && o_int_oe);
    end
  end
endmodule // plti_top

/* plti_top_assertions.sv */
// port checker for the threshold interrupt block
`timescale 1ns/100ps
module plti_chk (
  input wire i_clk, // block clock
  input wire i_rst, // sync reset
  input wire i_scl, // bus clock pin
  input wire i_prox_valid, // proximity strobe
  input wire i_light_valid, // light strobe
  input wire o_sda_o, // data drive value
  input wire o_sda_oe, // data pull-low enable
  input wire o_int_o, // interrupt drive value
  input wire o_int_oe // interrupt pull-low enable
);
  reg [4:0] evt_cnt_r; // cycles since bus or strobe activity
  reg [3:0] hi_cnt_r; // cycles with scl high
  always @(posedge i_clk) begin
    if (i_rst || !i_scl || i_prox_valid || i_light_valid) begin
      evt_cnt_r <= 5'h00;
    end else if (evt_cnt_r != 5'h1f) begin
      evt_cnt_r <= evt_cnt_r + 5'h01;
    end
    if (i_rst || !i_scl) begin
      hi_cnt_r <= 4'h0;
    end else if (hi_cnt_r != 4'hf) begin
      hi_cnt_r <= hi_cnt_r + 4'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_int_val; o_int_o == 1'b0; endproperty
  a_int_val: assert property (p_int_val)
    else $error("interrupt drive value not low");
  property p_sda_val; o_sda_o == 1'b0; endproperty
  a_sda_val: assert property (p_sda_val)
    else $error("data drive value not low");
  property p_rst_idle;
    $fell(i_rst) |-> (!o_int_oe && !o_sda_oe) [*2];
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("pins not released after reset");
  property p_sda_at_low; $changed(o_sda_oe) |-> !$past(i_scl, 2); endproperty
  a_sda_at_low: assert property (p_sda_at_low)
    else $error("data drive changed outside clock low");
  property p_sda_hold; i_scl [*3] |-> $stable(o_sda_oe); endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("data drive changed while clock high");
  property p_sda_idle; hi_cnt_r >= 4'ha |-> !o_sda_oe; endproperty
  a_sda_idle: assert property (p_sda_idle)
    else $error("data held low on idle bus");
  property p_int_rise; $rose(o_int_oe) |-> evt_cnt_r <= 5'h1a; endproperty
  a_int_rise: assert property (p_int_rise)
    else $error("interrupt asserted without a cause");
  property p_int_fall; $fell(o_int_oe) |-> evt_cnt_r <= 5'h1a; endproperty
  a_int_fall: assert property (p_int_fall)
    else $error("interrupt released without a cause");
endmodule // plti_chk

bind plti_top plti_chk u_chk (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_scl(i_scl),
  .i_prox_valid(i_prox_valid),
  .i_light_valid(i_light_valid),
  .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe),
  .o_int_o(o_int_o),
  .o_int_oe(o_int_oe)
);

/* plti_host.sv */
// serial bus master standing in for the host controller
`timescale 1ns/100ps
module plti_host (
  output reg o_scl, // bus clock, idles high
  output reg o_sda_low, // pull data low
  input wire i_sda // resolved data line
);
  integer lo_ext = 0; // extra clock low time when stalling
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic bitx(input logic v, output logic s);
    #(100 + lo_ext) o_sda_low = !v;
    #100 o_scl = 1'b1;
    #150 s = i_sda;
    #50 o_scl = 1'b0;
  endtask
  task automatic start;
    #100 o_sda_low = 1'b0;
    #100 o_scl = 1'b1;
    #200 o_sda_low = 1'b1;
    #200 o_scl = 1'b0;
  endtask
  task automatic stop;
    #100 o_sda_low = 1'b1;
    #100 o_scl = 1'b1;
    #200 o_sda_low = 1'b0;
    #200;
  endtask
  task automatic wbyte(input logic [7:0] b, inout logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
    end
    bitx(1'b1, s);
    nak = nak | s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, dat,
                    output logic nak);
    nak = 1'b0;
    start();
    wbyte({a, 1'b0}, nak);
    wbyte(p, nak);
    wbyte(dat, nak);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [7:0] dat, output logic nak);
    logic s;
    nak = 1'b0;
    start();
    wbyte({a, 1'b0}, nak);
    wbyte(p, nak);
    start();
    wbyte({a, 1'b1}, nak);
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, dat[i]);
    end
    // last byte, so the master answers with no acknowledge
    bitx(1'b1, s);
    stop();
  endtask
endmodule // plti_host

/* plti_top_tb.sv */
// self-checking bench for the threshold interrupt block
`timescale 1ns/100ps
`include "plti_consts.vh"
module plti_top_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_addr_sel = 1'b0;
  logic i_prox_valid = 1'b0;
  logic i_light_valid = 1'b0;
  logic [11:0] i_prox_high_thr = 12'h200;
  logic [11:0] i_prox_data = 12'h000;
  logic [15:0] i_light_data = 16'h0000;
  wire scl, host_low, o_sda_o, o_sda_oe, o_int_o, o_int_oe;
  wire sda = !(host_low || (o_sda_oe && !o_sda_o)); // pulled up
  wire int_n = !(o_int_oe && !o_int_o); // pulled up
  int n_errors = 0;
  int checks = 0;
  logic [7:0] q[$];
  logic [7:0] res_v, e_w, d, last;
  logic [6:0] dev = `PLTI_I2C_ADDR_BASE;
  logic [31:0] seed = 32'h82b9;
  logic nak;
  event res_ev;
  // rows: control byte, expected pin, result (light when control bit 1)
  logic [31:0] tv[18] = '{32'h0510_0200, 32'h0510_0200, 32'h0500_01ff,
    32'h1510_0201, 32'h1510_0150, 32'h1500_00ff, 32'h1500_0200,
    32'h2510_00ff, 32'h2500_0100, 32'h2500_0200, 32'h2510_0201,
    32'h3500_0201, 32'h0400_0fff, 32'h0610_1001, 32'h0600_1000,
    32'h0610_00ff, 32'h0600_0100, 32'h0710_0100};
  logic [7:0] thv[6] = '{8'h00, 8'h01, 8'h00, 8'h10, 8'h00, 8'h01};
  plti_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel),
    .o_int_o(o_int_o), .o_int_oe(o_int_oe),
    .i_prox_high_thr(i_prox_high_thr), .i_prox_valid(i_prox_valid),
    .i_prox_data(i_prox_data), .i_light_valid(i_light_valid),
    .i_light_data(i_light_data));
  plti_host host (.o_scl(scl), .o_sda_low(host_low), .i_sda(sda));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic res(input logic [7:0] v);
    res_v = v;
    -> res_ev;
    #1;
  endtask
  task automatic pin(input logic e);
    q.push_back({7'h00, e});
    res({7'h00, !int_n});
  endtask
  task automatic wr(input logic [7:0] a, dat);
    @(negedge i_clk);
    #7 host.wr(dev, a, dat, nak);
  endtask
  task automatic rd(input logic [7:0] a, e);
    q.push_back(e);
    @(negedge i_clk);
    #7 host.rd(dev, a, d, nak);
    res(d);
  endtask
  task automatic ack(input logic [6:0] a, input logic e);
    q.push_back({7'h00, e});
    @(negedge i_clk);
    #7 host.wr(a, 8'h60, 8'h00, nak);
    res({7'h00, nak});
  endtask
  task automatic st(input logic lt, input logic [15:0] v, input logic e);
    @(negedge i_clk);
    i_prox_data = v[11:0];
    i_light_data = v;
    i_prox_valid = !lt;
    i_light_valid = lt;
    @(negedge i_clk);
    i_prox_valid = 1'b0;
    i_light_valid = 1'b0;
    repeat (2) @(negedge i_clk);
    pin(e);
  endtask
  task automatic summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    forever #25 i_clk = !i_clk;
  end
  initial begin
    forever begin
      @(res_ev);
      checks++;
      e_w = (q.size() != 0) ? q.pop_front() : 8'hxx;
      if (e_w !== res_v) begin
        n_errors++;
        $display("[ERR] %0t got %h expected %h", $time, res_v, e_w);
      end
    end
  end
  initial begin
    #2_000_000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    pin(1'b0);
    for (int i = 0; i < 6; i++) begin
      rd(`PLTI_REG_PLT_LO + 8'(i), (i == 2 || i == 3) ? 8'hff : 8'h00);
    end
    rd(`PLTI_REG_INT_CTRL, 8'h00);
    rd(`PLTI_REG_PERSIST, 8'h00);
    rd(8'h60, 8'h00);
    ack(dev, 1'b0);
    ack(dev | 7'h01, 1'b1);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr(`PLTI_REG_PLT_LO + 8'(i), seed[7:0]);
      rd(`PLTI_REG_PLT_LO + 8'(i), seed[7:0] & (i == 1 ? 8'h0f : 8'hff));
      wr(`PLTI_REG_PLT_LO + 8'(i), thv[i]);
    end
    last = 8'h00;
    for (int i = 0; i < 18; i++) begin
      if (i == 13) begin
        wr(`PLTI_REG_PERSIST, 8'h02);
        wr(`PLTI_REG_INT_CTRL, 8'h05);
        st(1'b0, 16'h0000, 1'b0);
        st(1'b0, 16'h0200, 1'b0);
        st(1'b0, 16'h0200, 1'b1);
        last = 8'h05;
      end
      if (tv[i][31:24] !== last) begin
        wr(`PLTI_REG_INT_CTRL, tv[i][31:24]);
      end
      last = tv[i][31:24];
      st(last[1], tv[i][15:0], tv[i][20]);
    end
    wr(`PLTI_REG_PERSIST, 8'h00);
    wr(`PLTI_REG_INT_CTRL, 8'h01);
    wr(`PLTI_REG_SYS_CMD, 8'h40);
    pin(1'b0);
    st(1'b0, 16'h0200, 1'b1);
    st(1'b0, 16'h0000, 1'b1);
    rd(`PLTI_REG_INT_CTRL, 8'h81);
    pin(1'b0);
    st(1'b0, 16'h0200, 1'b1);
    wr(`PLTI_REG_SYS_CMD, 8'h80);
    pin(1'b0);
    rd(`PLTI_REG_INT_CTRL, 8'h00);
    rd(`PLTI_REG_PLT_HI, 8'h00);
    wr(`PLTI_REG_INT_CTRL, 8'h0d);
    st(1'b0, 16'h0200, 1'b1);
    st(1'b0, 16'h0200, 1'b0);
    repeat (25) @(negedge i_clk);
    pin(1'b1);
    // slower host at the alternate address
    host.lo_ext = 150;
    i_addr_sel = 1'b1;
    dev = `PLTI_I2C_ADDR_BASE | 7'h01;
    repeat (8) @(negedge i_clk);
    ack(dev, 1'b0);
    ack(`PLTI_I2C_ADDR_BASE, 1'b1);
    rd(`PLTI_REG_LHT_HI, 8'hff);
    summarize();
  end
endmodule // plti_top_tb
